// ===== include/tcc_map.svh
// register offsets, field positions, codes and reset values of the timer core
`ifndef TCC_MAP_SVH
`define TCC_MAP_SVH

// register byte offsets on the bus
`define TCC_OFF_CTRL_A    8'h00
`define TCC_OFF_CTRL_B    8'h04
`define TCC_OFF_CTRL_C    8'h08
`define TCC_OFF_COUNT     8'h0c
`define TCC_OFF_CMP_A     8'h10
`define TCC_OFF_CMP_B     8'h14
`define TCC_OFF_IRQ_MASK  8'h18
`define TCC_OFF_IRQ_FLAG  8'h1c

// control_reg_a fields
`define TCC_A_COM_A       7:6
`define TCC_A_COM_B       5:4
`define TCC_A_WGM_LO      1:0
// control_reg_b fields
`define TCC_B_WGM_HI      3
`define TCC_B_CS          2:0
// control_reg_c strobes
`define TCC_C_FORCE_A     7
`define TCC_C_FORCE_B     6

// flag and mask bit positions
`define TCC_IRQ_OVF       0
`define TCC_IRQ_MA        1
`define TCC_IRQ_MB        2
`define TCC_NUM_IRQ       3

// clock select codes
`define TCC_CS_STOP       3'h0
`define TCC_CS_DIV1       3'h1
`define TCC_CS_DIV8       3'h2
`define TCC_CS_DIV64      3'h3
`define TCC_CS_DIV256     3'h4
`define TCC_CS_DIV1024    3'h5
`define TCC_CS_EXT_FALL   3'h6
`define TCC_CS_EXT_RISE   3'h7

// compare output mode codes
`define TCC_COM_OFF       2'h0
`define TCC_COM_TOGGLE    2'h1
`define TCC_COM_CLEAR     2'h2
`define TCC_COM_SET       2'h3

// counter extremes and reset values
`define TCC_BOTTOM        8'h00
`define TCC_MAX           8'hff
`define TCC_ONE           8'h01
`define TCC_RST_BYTE      8'h00
`define TCC_RST_IRQ       3'h0
`define TCC_RST_WORD      32'h0000_0000

`endif

// ===== include/tcc_pkg.sv
// types shared by the timer core and its bench
package tcc_pkg;

  // waveform modes, the three-bit mode field
  typedef enum logic [2:0] {
    TCC_NORMAL   = 3'b000,
    TCC_PHASE_FF = 3'b001,
    TCC_CTC      = 3'b010,
    TCC_FAST_FF  = 3'b011,
    TCC_RSVD_4   = 3'b100,
    TCC_PHASE_A  = 3'b101,
    TCC_RSVD_6   = 3'b110,
    TCC_FAST_A   = 3'b111
  } tcc_wgm_t;

  // wishbone request from the master
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } tcc_wb_req_t;

  // wishbone answer of the slave
  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } tcc_wb_rsp_t;

  // whole state of the core
  typedef struct packed {
    logic [7:0]  ctrl_a;
    logic [7:0]  ctrl_b;
    logic [7:0]  cnt;
    logic [7:0]  cmp_a;
    logic [7:0]  cmp_b;
    logic [7:0]  buf_a;
    logic [7:0]  buf_b;
    logic [2:0]  mask;
    logic [2:0]  flag;
    logic [2:0]  irq;
    logic [1:0]  oc;
    logic [1:0]  pin;
    logic [1:0]  ovr;
    logic        down;
    logic        block;
    logic [2:0]  sync;
    tcc_wb_rsp_t rsp;
  } tcc_state_t;

endpackage

// ===== design/tcc_core.sv
// 8-bit timer/counter with two compare channels behind a wishbone slave
//
// The implementer's own choices: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "tcc_map.svh"

module tcc_core (
  // clock and reset
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  // register bus
  input  wire tcc_pkg::tcc_wb_req_t wb_req_i,
  output var  tcc_pkg::tcc_wb_rsp_t wb_rsp_o,
  // timer clock sources
  input  wire logic [3:0]          presc_tap_i,
  input  wire logic                ext_count_input_i,
  // interrupt handshake
  input  wire logic [2:0]          irq_ack_i,
  output logic      [2:0]          irq_req_o,
  // compare pins
  input  wire logic [1:0]          port_data_i,
  output logic                     compare_out_a_o,
  output logic                     compare_out_b_o,
  output logic      [1:0]          pin_override_o
);

  //////////////////////////////////////////////////////////////////////////////
  // decode of state and bus

  tcc_pkg::tcc_state_t s_q;
  tcc_pkg::tcc_state_t s_d;
  tcc_pkg::tcc_wgm_t   wgm;
  logic                tick;
  logic                pwm;
  logic                phase;
  logic [7:0]          top;
  logic                at_top;
  logic                at_bot;
  logic                at_max;
  logic                match_a;
  logic                match_b;
  logic                acc;
  logic                wr;
  logic                cnt_wr;
  logic                force_wr;
  logic [2:0]          flag_set;
  logic [2:0]          flag_clr;
  logic [1:0]          ext_s;

  // request taken while ack is low; a write commits at the edge where ack is seen high
  assign acc      = wb_req_i.cyc & wb_req_i.stb & ~s_q.rsp.ack;
  assign wr       = wb_req_i.cyc & wb_req_i.stb & s_q.rsp.ack & wb_req_i.we & wb_req_i.sel[0];
  assign cnt_wr   = wr && (wb_req_i.adr == `TCC_OFF_COUNT);
  assign force_wr = wr && (wb_req_i.adr == `TCC_OFF_CTRL_C);

  // mode field and the derived extremes
  assign wgm    = tcc_pkg::tcc_wgm_t'({s_q.ctrl_b[`TCC_B_WGM_HI],
                                       s_q.ctrl_a[`TCC_A_WGM_LO]});
  assign pwm    = (wgm == tcc_pkg::TCC_PHASE_FF) || (wgm == tcc_pkg::TCC_FAST_FF)
               || (wgm == tcc_pkg::TCC_PHASE_A) || (wgm == tcc_pkg::TCC_FAST_A);
  assign phase  = (wgm == tcc_pkg::TCC_PHASE_FF) || (wgm == tcc_pkg::TCC_PHASE_A);
  assign top    = ((wgm == tcc_pkg::TCC_PHASE_A) || (wgm == tcc_pkg::TCC_FAST_A))
               ? s_q.cmp_a : `TCC_MAX;
  assign at_top = (s_q.cnt == top);
  assign at_bot = (s_q.cnt == `TCC_BOTTOM);
  assign at_max = (s_q.cnt == `TCC_MAX);

  // comparators, silenced for the tick after a counter write
  assign match_a = (s_q.cnt == s_q.cmp_a) & ~s_q.block;
  assign match_b = (s_q.cnt == s_q.cmp_b) & ~s_q.block;

  // synchronised external level: second and third stage only
  assign ext_s = s_q.sync[2:1];

  //////////////////////////////////////////////////////////////////////////////
  // timer tick from the clock select field

  always_comb begin
    unique case (s_q.ctrl_b[`TCC_B_CS])
      `TCC_CS_STOP:     tick = 1'b0;
      `TCC_CS_DIV1:     tick = 1'b1;
      `TCC_CS_DIV8:     tick = presc_tap_i[0];
      `TCC_CS_DIV64:    tick = presc_tap_i[1];
      `TCC_CS_DIV256:   tick = presc_tap_i[2];
      `TCC_CS_DIV1024:  tick = presc_tap_i[3];
      `TCC_CS_EXT_FALL: tick = ext_s[1] & ~ext_s[0];
      `TCC_CS_EXT_RISE: tick = ext_s[0] & ~ext_s[1];
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    logic [1:0] com [2];
    logic [1:0] mt;
    s_d          = s_q;
    com[0]       = s_q.ctrl_a[`TCC_A_COM_A];
    com[1]       = s_q.ctrl_a[`TCC_A_COM_B];
    mt           = {match_b, match_a};
    flag_set     = `TCC_RST_IRQ;
    flag_clr     = irq_ack_i;
    s_d.sync     = {s_q.sync[1:0], ext_count_input_i};
    s_d.rsp.ack  = acc;
    s_d.rsp.dat  = `TCC_RST_WORD;

    // counting sequence per mode
    if (tick) begin
      s_d.block = 1'b0;
      flag_set[`TCC_IRQ_MA] = match_a;
      flag_set[`TCC_IRQ_MB] = match_b;
      unique case (wgm)
        tcc_pkg::TCC_NORMAL, tcc_pkg::TCC_RSVD_4, tcc_pkg::TCC_RSVD_6: begin
          s_d.cnt = s_q.cnt + `TCC_ONE;
          flag_set[`TCC_IRQ_OVF] = at_max;
        end
        tcc_pkg::TCC_CTC: begin
          s_d.cnt = (s_q.cnt == s_q.cmp_a) ? `TCC_BOTTOM : s_q.cnt + `TCC_ONE;
          flag_set[`TCC_IRQ_OVF] = at_max;
        end
        tcc_pkg::TCC_FAST_FF, tcc_pkg::TCC_FAST_A: begin
          s_d.cnt = at_top ? `TCC_BOTTOM : s_q.cnt + `TCC_ONE;
          flag_set[`TCC_IRQ_OVF] = at_top;
        end
        tcc_pkg::TCC_PHASE_FF, tcc_pkg::TCC_PHASE_A: begin
          if (s_q.down && at_bot) begin
            s_d.down = 1'b0;
            s_d.cnt  = s_q.cnt + `TCC_ONE;
            flag_set[`TCC_IRQ_OVF] = 1'b1;
          end else if (!s_q.down && at_top) begin
            s_d.down = 1'b1;
            s_d.cnt  = s_q.cnt - `TCC_ONE;
          end else if (s_q.down) begin
            s_d.cnt  = s_q.cnt - `TCC_ONE;
          end else begin
            s_d.cnt  = s_q.cnt + `TCC_ONE;
          end
        end
      endcase
      // buffered compares load at top, the step into bottom for fast pwm
      if (pwm && at_top) begin
        s_d.cmp_a = s_q.buf_a;
        s_d.cmp_b = s_q.buf_b;
      end
    end
    if (!phase) begin
      s_d.down = 1'b0;
    end

    // waveform generator per channel, output mode read live
    for (int i = 0; i < 2; i++) begin
      if (tick && mt[i]) begin
        if (!pwm) begin
          unique case (com[i])
            `TCC_COM_OFF:    s_d.oc[i] = s_q.oc[i];
            `TCC_COM_TOGGLE: s_d.oc[i] = ~s_q.oc[i];
            `TCC_COM_CLEAR:  s_d.oc[i] = 1'b0;
            `TCC_COM_SET:    s_d.oc[i] = 1'b1;
          endcase
        end else if (com[i] == `TCC_COM_TOGGLE) begin
          s_d.oc[i] = (i == 0) && wgm[2] ? ~s_q.oc[i] : s_q.oc[i];
        end else if (com[i] != `TCC_COM_OFF) begin
          s_d.oc[i] = (com[i] == `TCC_COM_SET) ^ (phase && s_q.down);
        end
      end
      // fast pwm restarts its pulse at bottom
      if (tick && pwm && !phase && at_top && com[i][1]) begin
        s_d.oc[i] = (com[i] == `TCC_COM_CLEAR);
      end
      // forced compare acts only in non-pwm modes
      if (force_wr && !pwm && wb_req_i.dat[`TCC_C_FORCE_A - i]) begin
        unique case (com[i])
          `TCC_COM_OFF:    s_d.oc[i] = s_q.oc[i];
          `TCC_COM_TOGGLE: s_d.oc[i] = ~s_q.oc[i];
          `TCC_COM_CLEAR:  s_d.oc[i] = 1'b0;
          `TCC_COM_SET:    s_d.oc[i] = 1'b1;
        endcase
      end
    end

    // register writes, applied after counting so the cpu wins except on the flag register
    if (wr) begin
      unique case (wb_req_i.adr)
        `TCC_OFF_CTRL_A:   s_d.ctrl_a = wb_req_i.dat[7:0];
        `TCC_OFF_CTRL_B:   s_d.ctrl_b = wb_req_i.dat[7:0];
        `TCC_OFF_COUNT: begin
          s_d.cnt   = wb_req_i.dat[7:0];
          s_d.block = 1'b1;
        end
        `TCC_OFF_CMP_A: begin
          s_d.buf_a = wb_req_i.dat[7:0];
          if (!pwm) begin
            s_d.cmp_a = wb_req_i.dat[7:0];
          end
        end
        `TCC_OFF_CMP_B: begin
          s_d.buf_b = wb_req_i.dat[7:0];
          if (!pwm) begin
            s_d.cmp_b = wb_req_i.dat[7:0];
          end
        end
        `TCC_OFF_IRQ_MASK: s_d.mask = wb_req_i.dat[2:0];
        `TCC_OFF_IRQ_FLAG: flag_clr = flag_clr | wb_req_i.dat[2:0];
        default:           s_d.mask = s_q.mask;
      endcase
    end

    // sticky flags, a new event outlives a clear in the same cycle
    s_d.flag = (s_q.flag & ~flag_clr) | flag_set;
    s_d.irq  = s_d.flag & s_d.mask;

    // port override from the live output mode
    s_d.ovr[0] = (s_d.ctrl_a[`TCC_A_COM_A] != `TCC_COM_OFF);
    s_d.ovr[1] = (s_d.ctrl_a[`TCC_A_COM_B] != `TCC_COM_OFF);
    for (int i = 0; i < 2; i++) begin
      s_d.pin[i] = s_d.ovr[i] ? s_d.oc[i] : port_data_i[i];
    end

    // read data, unmapped offsets read zero
    if (acc && !wb_req_i.we) begin
      unique case (wb_req_i.adr)
        `TCC_OFF_CTRL_A:   s_d.rsp.dat[7:0] = s_q.ctrl_a;
        `TCC_OFF_CTRL_B:   s_d.rsp.dat[7:0] = s_q.ctrl_b;
        `TCC_OFF_COUNT:    s_d.rsp.dat[7:0] = s_q.cnt;
        `TCC_OFF_CMP_A:    s_d.rsp.dat[7:0] = pwm ? s_q.buf_a : s_q.cmp_a;
        `TCC_OFF_CMP_B:    s_d.rsp.dat[7:0] = pwm ? s_q.buf_b : s_q.cmp_b;
        `TCC_OFF_IRQ_MASK: s_d.rsp.dat[2:0] = s_q.mask;
        `TCC_OFF_IRQ_FLAG: s_d.rsp.dat[2:0] = s_q.flag;
        default:           s_d.rsp.dat      = `TCC_RST_WORD;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs straight from the state register
  assign wb_rsp_o        = s_q.rsp;
  assign irq_req_o       = s_q.irq;
  assign compare_out_a_o = s_q.pin[0];
  assign compare_out_b_o = s_q.pin[1];
  assign pin_override_o  = s_q.ovr;

  //////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_count_write;
    cnt_wr;
  endsequence

  sequence s_blocked_tick;
    tick && (s_q.cnt == s_q.cmp_a) && !cnt_wr && !irq_ack_i[`TCC_IRQ_MA]
      && !(wr && wb_req_i.adr == `TCC_OFF_IRQ_FLAG);
  endsequence

  a_stop_holds_count: assert property (
    (s_q.ctrl_b[`TCC_B_CS] == `TCC_CS_STOP) && !cnt_wr |=> $stable(s_q.cnt))
    else $error("counter moved while stopped");

  a_write_wins_count: assert property (
    cnt_wr |=> (s_q.cnt == $past(wb_req_i.dat[7:0])) && s_q.block)
    else $error("counter write lost");

  a_block_after_write: assert property (
    s_count_write ##1 (s_blocked_tick and !s_q.flag[`TCC_IRQ_MA])
      |=> !s_q.flag[`TCC_IRQ_MA])
    else $error("match not blocked after counter write");

  a_match_sets_flag: assert property (
    s_blocked_tick and !s_q.block |=> s_q.flag[`TCC_IRQ_MA])
    else $error("compare a match did not set flag");

  a_flag_w1c: assert property (
    wr && (wb_req_i.adr == `TCC_OFF_IRQ_FLAG) && wb_req_i.dat[`TCC_IRQ_MB] && !tick
      |=> !s_q.flag[`TCC_IRQ_MB])
    else $error("flag b not cleared by write one");

  a_normal_wrap: assert property (
    (wgm == tcc_pkg::TCC_NORMAL) && tick && at_max && !cnt_wr
      |=> (s_q.cnt == `TCC_BOTTOM) && s_q.flag[`TCC_IRQ_OVF])
    else $error("normal mode wrap wrong");

  a_ctc_clear: assert property (
    (wgm == tcc_pkg::TCC_CTC) && tick && (s_q.cnt == s_q.cmp_a) && !cnt_wr
      |=> s_q.cnt == `TCC_BOTTOM)
    else $error("clear-on-match mode did not clear");

  a_irq_masked: assert property (
    (irq_req_o & ~s_q.mask) == `TCC_RST_IRQ && irq_req_o == (s_q.flag & s_q.mask))
    else $error("interrupt request not masked");

  a_force_no_flag: assert property (
    force_wr && !pwm && !tick && !cnt_wr && (irq_ack_i == `TCC_RST_IRQ)
      |=> $stable(s_q.flag) && $stable(s_q.cnt))
    else $error("force touched flag or counter");

  a_pin_override: assert property (
    s_q.pin[0] == (s_q.ovr[0] ? s_q.oc[0] : $past(port_data_i[0])))
    else $error("compare pin a override wrong");

  a_pwm_buffer_hold: assert property (
    pwm && !(tick && at_top) && !(wr && wb_req_i.adr == `TCC_OFF_CTRL_A)
      && !(wr && wb_req_i.adr == `TCC_OFF_CTRL_B) |=> $stable(s_q.cmp_a))
    else $error("active compare changed away from top");

  a_div1_step: assert property (
    (s_q.ctrl_b[`TCC_B_CS] == `TCC_CS_DIV1) && (wgm == tcc_pkg::TCC_NORMAL) && !cnt_wr
      |=> s_q.cnt == $past(s_q.cnt) + `TCC_ONE)
    else $error("full-rate clock did not step counter");

  a_phase_bottom_ovf: assert property (
    tick && phase && s_q.down && at_bot && !cnt_wr
      |=> s_q.flag[`TCC_IRQ_OVF] && !s_q.down)
    else $error("phase correct overflow missing at bottom");

  a_pwm_top_load: assert property (
    tick && pwm && at_top |=> s_q.cmp_a == $past(s_q.buf_a))
    else $error("buffer not loaded at top");

  sequence s_pin_rose;
    (s_q.ctrl_b[`TCC_B_CS] == `TCC_CS_EXT_RISE) && ext_count_input_i
      && !s_q.sync[0] && !s_q.sync[1];
  endsequence

  sequence s_rise_held;
    (s_q.ctrl_b[`TCC_B_CS] == `TCC_CS_EXT_RISE) [*2];
  endsequence

  a_ext_rise_tick: assert property (
    s_pin_rose ##1 s_rise_held |-> tick)
    else $error("external rising edge gave no tick");

  a_pin_override_b: assert property (
    s_q.pin[1] == (s_q.ovr[1] ? s_q.oc[1] : $past(port_data_i[1])))
    else $error("compare pin b override wrong");

  a_ack_clears_flag: assert property (
    irq_ack_i[`TCC_IRQ_MA] && !(tick && match_a) |=> !s_q.flag[`TCC_IRQ_MA])
    else $error("interrupt ack did not clear flag a");

endmodule

`default_nettype wire

// ===== test/tcc_src_model.sv
// prescaler taps and external count pin driven towards the timer core
`timescale 1ns/1ps
`default_nettype none
module tcc_src_model (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // timer clock sources
  output logic      [3:0] presc_tap_o,
  output logic            ext_pin_o
);
  logic [9:0] div_q;
  logic       one_q;
  // free-running upper taps; the /8 tap pulses only on request
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_q <= 10'h000;
    end else begin
      div_q <= div_q + 10'h001;
    end
  end
  assign presc_tap_o = {div_q == 10'h3ff, div_q[7:0] == 8'hff, div_q[5:0] == 6'h3f, one_q};
  // quiet sources from time zero
  initial begin
    one_q = 1'b0;
    ext_pin_o = 1'b0;
  end
  // one /8 tap pulse, one cycle wide
  task automatic tick8();
    @(posedge clk_i);
    one_q <= 1'b1;
    @(posedge clk_i);
    one_q <= 1'b0;
  endtask
  // move the external count pin to a level
  task automatic set_pin(input logic lvl);
    @(posedge clk_i);
    ext_pin_o <= lvl;
  endtask
endmodule
`default_nettype wire

// ===== test/tcc_core_tb_top.sv
// self-checking bench of the timer core
`timescale 1ns/1ps
`default_nettype none
`include "tcc_map.svh"
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin err_total++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e); end end
module tcc_core_tb_top;
  logic                 clk_i;
  logic                 rst_i;
  tcc_pkg::tcc_wb_req_t req;
  tcc_pkg::tcc_wb_rsp_t rsp;
  logic [3:0]           taps;
  logic                 ext_pin;
  logic [2:0]           irq_ack;
  logic [2:0]           irq_req;
  logic [1:0]           port_data;
  logic                 out_a;
  logic                 out_b;
  logic [1:0]           ovr;
  logic [7:0]           rd;
  int                   err_total = 0;
  int                   cmp_count = 0;
  int                   cyc_n = 0;

  tcc_core dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(req), .wb_rsp_o(rsp),
    .presc_tap_i(taps), .ext_count_input_i(ext_pin), .irq_ack_i(irq_ack),
    .irq_req_o(irq_req), .port_data_i(port_data), .compare_out_a_o(out_a),
    .compare_out_b_o(out_b), .pin_override_o(ovr));
  tcc_src_model src_u (.clk_i(clk_i), .rst_i(rst_i), .presc_tap_o(taps), .ext_pin_o(ext_pin));

  ////////////////////////////////////////////////////////////////////////////
  // clock and hang guard
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cyc_n++;
    if (cyc_n == 20000) begin
      err_total++;
      tally_and_finish();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus access; answer sampled at the edge where ack is seen high
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    req <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: a, sel: 4'h1, dat: {24'h000000, d}};
    do begin
      @(posedge clk_i);
    end while (rsp.ack !== 1'b1);
    `CHK(rsp.ack, 1'b1);
    rd = rsp.dat[7:0];
    req <= '0;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    wb(1'b0, a, 8'h00);
    `CHK(rd, e);
  endtask
  task automatic ticks(input int n);
    repeat (n) src_u.tick8();
    repeat (2) @(posedge clk_i);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_reset();
    rdchk(`TCC_OFF_COUNT, 8'h00);
    rdchk(`TCC_OFF_CMP_A, 8'h00);
    rdchk(`TCC_OFF_IRQ_FLAG, 8'h00);
    rdchk(8'h40, 8'h00);
    `CHK(out_a, 1'b0);
    wb(1'b1, `TCC_OFF_COUNT, 8'h42);
    idle(10);
    rdchk(`TCC_OFF_COUNT, 8'h42);
    $display("test reset_stop done");
  endtask
  task automatic t_match();
    wb(1'b1, `TCC_OFF_CTRL_B, 8'h02);
    wb(1'b1, `TCC_OFF_CMP_A, 8'h43);
    wb(1'b1, `TCC_OFF_COUNT, 8'h43);
    ticks(1);
    rdchk(`TCC_OFF_COUNT, 8'h44);
    rdchk(`TCC_OFF_IRQ_FLAG, 8'h00);
    wb(1'b1, `TCC_OFF_CMP_B, 8'hff);
    wb(1'b1, `TCC_OFF_COUNT, 8'hfe);
    ticks(2);
    rdchk(`TCC_OFF_COUNT, 8'h00);
    rdchk(`TCC_OFF_IRQ_FLAG, 8'h05);
    wb(1'b1, `TCC_OFF_IRQ_MASK, 8'h04);
    idle(2);
    `CHK(irq_req, 3'b100);
    wb(1'b1, `TCC_OFF_IRQ_FLAG, 8'h04);
    rdchk(`TCC_OFF_IRQ_FLAG, 8'h01);
    `CHK(irq_req, 3'b000);
    @(posedge clk_i);
    irq_ack <= 3'b001;
    @(posedge clk_i);
    irq_ack <= 3'b000;
    rdchk(`TCC_OFF_IRQ_FLAG, 8'h00);
    $display("test match_overflow done");
  endtask
  task automatic t_ctc_buf();
    wb(1'b1, `TCC_OFF_CTRL_A, 8'h02);
    wb(1'b1, `TCC_OFF_CMP_A, 8'h02);
    wb(1'b1, `TCC_OFF_COUNT, 8'h00);
    ticks(3);
    rdchk(`TCC_OFF_COUNT, 8'h00);
    rdchk(`TCC_OFF_IRQ_FLAG, 8'h02);
    wb(1'b1, `TCC_OFF_CTRL_A, 8'h00);
    wb(1'b1, `TCC_OFF_CMP_B, 8'h55);
    rdchk(`TCC_OFF_CMP_B, 8'h55);
    wb(1'b1, `TCC_OFF_CTRL_A, 8'h03);
    wb(1'b1, `TCC_OFF_CMP_B, 8'h20);
    rdchk(`TCC_OFF_CMP_B, 8'h20);
    wb(1'b1, `TCC_OFF_IRQ_FLAG, 8'h07);
    wb(1'b1, `TCC_OFF_COUNT, 8'h54);
    ticks(2);
    rdchk(`TCC_OFF_IRQ_FLAG, 8'h04);
    $display("test ctc_buffer done");
  endtask
  task automatic t_force();
    wb(1'b1, `TCC_OFF_CTRL_A, 8'hc0);
    wb(1'b1, `TCC_OFF_IRQ_FLAG, 8'h07);
    idle(2);
    `CHK(ovr, 2'b01);
    `CHK(out_a, 1'b0);
    wb(1'b1, `TCC_OFF_CTRL_C, 8'h80);
    idle(2);
    `CHK(out_a, 1'b1);
    rdchk(`TCC_OFF_IRQ_FLAG, 8'h00);
    rdchk(`TCC_OFF_COUNT, 8'h56);
    wb(1'b1, `TCC_OFF_CTRL_A, 8'h00);
    idle(2);
    `CHK(out_a, 1'b0);
    port_data <= 2'b01;
    idle(3);
    `CHK(out_a, 1'b1);
    port_data <= 2'b00;
    wb(1'b1, `TCC_OFF_CTRL_A, 8'hc3);
    idle(2);
    `CHK(out_a, 1'b1);
    $display("test force_output done");
  endtask
  task automatic t_ext();
    wb(1'b1, `TCC_OFF_CTRL_A, 8'h00);
    wb(1'b1, `TCC_OFF_CTRL_B, 8'h07);
    wb(1'b1, `TCC_OFF_COUNT, 8'h10);
    src_u.set_pin(1'b1);
    idle(8);
    rdchk(`TCC_OFF_COUNT, 8'h11);
    src_u.set_pin(1'b0);
    idle(8);
    rdchk(`TCC_OFF_COUNT, 8'h11);
    wb(1'b1, `TCC_OFF_CTRL_B, 8'h06);
    src_u.set_pin(1'b1);
    idle(8);
    src_u.set_pin(1'b0);
    idle(8);
    rdchk(`TCC_OFF_COUNT, 8'h12);
    wb(1'b1, `TCC_OFF_CTRL_B, 8'h00);
    src_u.set_pin(1'b1);
    idle(8);
    rdchk(`TCC_OFF_COUNT, 8'h12);
    $display("test ext_source done");
  endtask
  task automatic t_pwm();
    // fast pwm with top from compare a, buffered compare, channel b clear mode
    wb(1'b1, `TCC_OFF_IRQ_FLAG, 8'h07);
    wb(1'b1, `TCC_OFF_CMP_A, 8'h03);
    wb(1'b1, `TCC_OFF_CMP_B, 8'h01);
    wb(1'b1, `TCC_OFF_CTRL_A, 8'h23);
    wb(1'b1, `TCC_OFF_CTRL_B, 8'h0a);
    wb(1'b1, `TCC_OFF_COUNT, 8'h00);
    wb(1'b1, `TCC_OFF_CMP_A, 8'h05);
    rdchk(`TCC_OFF_CMP_A, 8'h05);
    `CHK(out_b, 1'b0);
    `CHK(ovr, 2'b10);
    ticks(4);
    rdchk(`TCC_OFF_COUNT, 8'h00);
    rdchk(`TCC_OFF_IRQ_FLAG, 8'h07);
    `CHK(out_b, 1'b1);
    @(posedge clk_i);
    irq_ack <= 3'b110;
    @(posedge clk_i);
    irq_ack <= 3'b000;
    rdchk(`TCC_OFF_IRQ_FLAG, 8'h01);
    wb(1'b1, `TCC_OFF_IRQ_FLAG, 8'h01);
    ticks(2);
    `CHK(out_b, 1'b0);
    ticks(2);
    rdchk(`TCC_OFF_COUNT, 8'h04);
    ticks(2);
    rdchk(`TCC_OFF_COUNT, 8'h00);
    rdchk(`TCC_OFF_IRQ_FLAG, 8'h07);
    // phase correct, overflow at bottom while counting down
    wb(1'b1, `TCC_OFF_CTRL_A, 8'h01);
    wb(1'b1, `TCC_OFF_IRQ_FLAG, 8'h07);
    wb(1'b1, `TCC_OFF_COUNT, 8'h04);
    ticks(6);
    rdchk(`TCC_OFF_COUNT, 8'h00);
    rdchk(`TCC_OFF_IRQ_FLAG, 8'h06);
    ticks(1);
    rdchk(`TCC_OFF_COUNT, 8'h01);
    rdchk(`TCC_OFF_IRQ_FLAG, 8'h07);
    // full-rate clock for three edges, then forced compare on channel b
    wb(1'b1, `TCC_OFF_CTRL_B, 8'h00);
    wb(1'b1, `TCC_OFF_CTRL_A, 8'h00);
    wb(1'b1, `TCC_OFF_COUNT, 8'h00);
    wb(1'b1, `TCC_OFF_CTRL_B, 8'h01);
    wb(1'b1, `TCC_OFF_CTRL_B, 8'h00);
    rdchk(`TCC_OFF_COUNT, 8'h03);
    wb(1'b1, `TCC_OFF_CTRL_A, 8'h10);
    idle(2);
    `CHK(ovr, 2'b10);
    `CHK(out_b, 1'b1);
    wb(1'b1, `TCC_OFF_CTRL_C, 8'h40);
    idle(2);
    `CHK(out_b, 1'b0);
    $display("test pwm_modes done");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    rst_i = 1'b1;
    req = '0;
    irq_ack = 3'b000;
    port_data = 2'b00;
    rd = 8'h00;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_match();
    t_ctc_buf();
    t_force();
    t_ext();
    t_pwm();
    tally_and_finish();
  end
endmodule
`default_nettype wire
